// ==== design/timer_ctrl.sv ====
// Timer 0/1 control, mode and counting logic with Avalon-MM slave
//
// How it works
// [RULE_01] External pin 0 condition sets its flag
// [RULE_02] Servicing clears edge flags, not level flags
// [RULE_03] Gating off: run bit alone enables
// [RULE_04] Gating on: run bit and pin high
// [RULE_05] Timer select counts divided system clock
// [RULE_06] Counter select counts pin falling edges
// [RULE_07] Overflow sets flag; service clears it
// [RULE_08] Mode 0: 5-bit prescaler feeds high byte
// [RULE_09] Mode 2: low byte reloads from high
// [RULE_10] Mode 3 splits timer 0; timer 1 holds
// [RULE_11] Mode field decodes four modes
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module timer_ctrl
    import timer_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              ext_irq0_pin,
    input  wire logic              ext_irq1_pin,
    input  wire logic              timer0_count_pin,
    input  wire logic              timer1_count_pin,
    output logic                   timer0_irq,
    output logic                   timer1_irq,
    output logic                   ext_irq0_irq,
    output logic                   ext_irq1_irq
);

    counter_control_t     ctrl_q;
    counter_control_t     ctrl_d;
    counter_mode_select_t mode_q;
    logic [7:0]           t0_low_q;
    logic [7:0]           t0_high_q;
    logic [7:0]           t1_low_q;
    logic [7:0]           t1_high_q;
    logic [7:0]           t0_low_d;
    logic [7:0]           t0_high_d;
    logic [7:0]           t1_low_d;
    logic [7:0]           t1_high_d;
    logic                 t0_ovf;
    logic                 t0h_ovf;
    logic                 t1_ovf;
    logic [2:0]           div_q;
    logic                 tick;
    logic                 wait_q;
    logic [DATA_W-1:0]    rdata_q;
    logic [7:0]           rd_byte;
    logic [PIN_W-1:0]     pin_level;
    logic [PIN_W-1:0]     pin_fall;
    logic                 split0;
    logic                 en0;
    logic                 en0h;
    logic                 en1;
    logic                 wr_go;
    logic [7:0]           wr_byte;
    logic [7:0]           wr_idx;
    count_step_t          s0;
    count_step_t          s1;

    pin_sync #(.W(PIN_W)) u_pin_sync
    (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .pin_async ({timer1_count_pin, timer0_count_pin,
                     ext_irq1_pin, ext_irq0_pin}),
        .level     (pin_level),
        .fall      (pin_fall)
    );

    // One count step of a timer in modes 0 to 2; mode 3 holds
    function automatic count_step_t step(
        input timer_mode_t m,
        input logic [7:0]  lo,
        input logic [7:0]  hi
    );
        count_step_t r;
        r = '{ovf: 1'b0, high: hi, low: lo};
        // [RULE_11] mode field decode
        case (m)
            // [RULE_08] prescaler carry into high byte
            MODE_13BIT:
            begin
                r.low = {lo[7:5], lo[4:0] + PRESC_ONE};
                if (lo[4:0] == PRESC_MAX)
                begin
                    r.high = hi + BYTE_ONE;
                    r.ovf  = (hi == BYTE_MAX);
                end
            end
            MODE_16BIT:
            begin
                r.low = lo + BYTE_ONE;
                if (lo == BYTE_MAX)
                begin
                    r.high = hi + BYTE_ONE;
                    r.ovf  = (hi == BYTE_MAX);
                end
            end
            // [RULE_09] reload low from high
            MODE_RELOAD:
            begin
                r.low = (lo == BYTE_MAX) ? hi : lo + BYTE_ONE;
                r.ovf = (lo == BYTE_MAX);
            end
            default:
            begin
                r.ovf = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Machine-cycle tick divider
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            div_q <= '0;
        else if (tick)
            div_q <= '0;
        else
            div_q <= div_q + TICK_ONE;
    end

    assign tick   = (div_q == TICK_LAST);
    assign split0 = (mode_q.timer0_mode == MODE_SPLIT);

    // Count enables
    always_comb
    begin
        // [RULE_03] [RULE_04] gating by run bit and pin
        // [RULE_05] [RULE_06] tick or pin falling edge
        en0 = ctrl_q.timer0_run_bit
            & (~mode_q.timer0_pin_gating | pin_level[PIN_IRQ0])
            & (mode_q.timer0_count_source_select ? pin_fall[PIN_T0]
                                                 : tick);
        // [RULE_10] high byte borrows timer 1 run bit
        en0h = split0 & ctrl_q.timer1_run_bit & tick;
        // Timer 1 loses its run bit to timer 0 while split
        en1 = (split0 | ctrl_q.timer1_run_bit)
            & (~mode_q.timer1_pin_gating | pin_level[PIN_IRQ1])
            & (mode_q.timer1_count_source_select ? pin_fall[PIN_T1]
                                                 : tick);
    end

    // Next counts
    always_comb
    begin
        s0 = step(mode_q.timer0_mode, t0_low_q, t0_high_q);
        s1 = step(mode_q.timer1_mode, t1_low_q, t1_high_q);
        t0_low_d  = t0_low_q;
        t0_high_d = t0_high_q;
        t1_low_d  = t1_low_q;
        t1_high_d = t1_high_q;
        t0_ovf    = 1'b0;
        t0h_ovf   = 1'b0;
        t1_ovf    = 1'b0;
        // [RULE_10] two independent 8-bit counters
        if (split0)
        begin
            if (en0)
            begin
                t0_low_d = t0_low_q + BYTE_ONE;
                t0_ovf   = (t0_low_q == BYTE_MAX);
            end
            if (en0h)
            begin
                t0_high_d = t0_high_q + BYTE_ONE;
                t0h_ovf   = (t0_high_q == BYTE_MAX);
            end
        end
        else if (en0)
        begin
            t0_low_d  = s0.low;
            t0_high_d = s0.high;
            t0_ovf    = s0.ovf;
        end
        // [RULE_10] mode 3 on timer 1 yields no step
        if (en1)
        begin
            t1_low_d  = s1.low;
            t1_high_d = s1.high;
            t1_ovf    = s1.ovf;
        end
    end

    // Bus request decode; action at the edge waitrequest is low
    assign wr_go   = avs_write & ~wait_q & avs_byteenable[0];
    assign wr_byte = avs_writedata[7:0];
    assign wr_idx  = avs_address[ADDR_W-1:2];

    // Count bytes; a software write wins over a count step
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            t0_low_q  <= BYTE_RESET;
            t0_high_q <= BYTE_RESET;
            t1_low_q  <= BYTE_RESET;
            t1_high_q <= BYTE_RESET;
        end
        else
        begin
            t0_low_q  <= (wr_go && wr_idx == IDX_T0_LOW)  ? wr_byte
                                                          : t0_low_d;
            t0_high_q <= (wr_go && wr_idx == IDX_T0_HIGH) ? wr_byte
                                                          : t0_high_d;
            t1_low_q  <= (wr_go && wr_idx == IDX_T1_LOW)  ? wr_byte
                                                          : t1_low_d;
            t1_high_q <= (wr_go && wr_idx == IDX_T1_HIGH) ? wr_byte
                                                          : t1_high_d;
        end
    end

    // Control flags: software first, hardware sets override
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_go && wr_idx == IDX_CTRL)
            ctrl_d = counter_control_t'(wr_byte);
        if (wr_go && wr_idx == IDX_SERVICE)
        begin
            // [RULE_07] vectoring clears overflow flags
            if (wr_byte[SVC_T0])
                ctrl_d.timer0_overflow_flag = 1'b0;
            if (wr_byte[SVC_T1])
                ctrl_d.timer1_overflow_flag = 1'b0;
            // [RULE_02] edge mode only
            if (wr_byte[SVC_EXT0] && ctrl_q.ext_irq0_edge_select)
                ctrl_d.ext_irq0_request_flag = 1'b0;
            if (wr_byte[SVC_EXT1] && ctrl_q.ext_irq1_edge_select)
                ctrl_d.ext_irq1_request_flag = 1'b0;
        end
        // [RULE_07] overflow sets flag
        if (t0_ovf)
            ctrl_d.timer0_overflow_flag = 1'b1;
        if (t0h_ovf || (t1_ovf && !split0))
            ctrl_d.timer1_overflow_flag = 1'b1;
        // [RULE_01] falling edge or low level, per select
        if (ctrl_q.ext_irq0_edge_select ? pin_fall[PIN_IRQ0]
                                        : ~pin_level[PIN_IRQ0])
            ctrl_d.ext_irq0_request_flag = 1'b1;
        if (ctrl_q.ext_irq1_edge_select ? pin_fall[PIN_IRQ1]
                                        : ~pin_level[PIN_IRQ1])
            ctrl_d.ext_irq1_request_flag = 1'b1;
    end

    // Control register
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            ctrl_q <= counter_control_t'(CTRL_RESET);
        else
            ctrl_q <= ctrl_d;
    end

    // Mode register; stop a timer before changing its mode
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            mode_q <= counter_mode_select_t'(MODE_RESET);
        else if (wr_go && wr_idx == IDX_MODE)
            mode_q <= counter_mode_select_t'(wr_byte);
    end

    // Read mux; unmapped addresses and the service register read 0
    always_comb
    begin
        case (wr_idx)
            IDX_CTRL:    rd_byte = ctrl_q;
            IDX_MODE:    rd_byte = mode_q;
            IDX_T0_LOW:  rd_byte = t0_low_q;
            IDX_T1_LOW:  rd_byte = t1_low_q;
            IDX_T0_HIGH: rd_byte = t0_high_q;
            IDX_T1_HIGH: rd_byte = t1_high_q;
            default:     rd_byte = BYTE_RESET;
        endcase
    end

    // One wait state per access so read data comes from a flop
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
        end
        else
        begin
            wait_q <= ~((avs_read | avs_write) & wait_q);
            if (avs_read && wait_q)
                rdata_q <= {{(DATA_W-8){1'b0}}, rd_byte};
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign timer0_irq      = ctrl_q.timer0_overflow_flag;
    assign timer1_irq      = ctrl_q.timer1_overflow_flag;
    assign ext_irq0_irq    = ctrl_q.ext_irq0_request_flag;
    assign ext_irq1_irq    = ctrl_q.ext_irq1_request_flag;

endmodule
`default_nettype wire

// ==== inc/timer_pkg.sv ====
// Shared constants and types for the timer control block
package timer_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int PIN_W  = 4;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL    = 8'h88;
    localparam logic [7:0] IDX_MODE    = 8'h89;
    localparam logic [7:0] IDX_T0_LOW  = 8'h8A;
    localparam logic [7:0] IDX_T1_LOW  = 8'h8B;
    localparam logic [7:0] IDX_T0_HIGH = 8'h8C;
    localparam logic [7:0] IDX_T1_HIGH = 8'h8D;
    localparam logic [7:0] IDX_SERVICE = 8'h90;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_MAX   = 8'hFF;
    localparam logic [7:0] BYTE_ONE   = 8'h01;
    localparam logic [4:0] PRESC_MAX  = 5'h1F;
    localparam logic [4:0] PRESC_ONE  = 5'h01;

    // Timer tick is the peripheral clock divided by six
    localparam logic [2:0] TICK_LAST = 3'h5;
    localparam logic [2:0] TICK_ONE  = 3'h1;

    // Service register bits (write one to acknowledge)
    localparam int SVC_EXT0 = 0;
    localparam int SVC_T0   = 1;
    localparam int SVC_EXT1 = 2;
    localparam int SVC_T1   = 3;

    // Pin vector positions
    localparam int PIN_IRQ0 = 0;
    localparam int PIN_IRQ1 = 1;
    localparam int PIN_T0   = 2;
    localparam int PIN_T1   = 3;

    typedef enum logic [1:0]
    {
        MODE_13BIT  = 2'h0,
        MODE_16BIT  = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT  = 2'h3
    } timer_mode_t;

    typedef struct packed
    {
        logic timer1_overflow_flag;
        logic timer1_run_bit;
        logic timer0_overflow_flag;
        logic timer0_run_bit;
        logic ext_irq1_request_flag;
        logic ext_irq1_edge_select;
        logic ext_irq0_request_flag;
        logic ext_irq0_edge_select;
    } counter_control_t;

    typedef struct packed
    {
        logic        timer1_pin_gating;
        logic        timer1_count_source_select;
        timer_mode_t timer1_mode;
        logic        timer0_pin_gating;
        logic        timer0_count_source_select;
        timer_mode_t timer0_mode;
    } counter_mode_select_t;

    typedef struct packed
    {
        logic       ovf;
        logic [7:0] high;
        logic [7:0] low;
    } count_step_t;

endpackage

// ==== design/pin_sync.sv ====
// Two-stage synchroniser with falling edge detect for the pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import timer_pkg::*;
#(
    parameter int W = PIN_W
)
(
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pin_async,
    output logic      [W-1:0] level,
    output logic      [W-1:0] fall
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // Pins idle high, so reset to ones to avoid a false edge
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end
        else
        begin
            meta_q <= pin_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge taken only after the second stage
    assign level = sync_q;
    assign fall  = prev_q & ~sync_q;

endmodule
`default_nettype wire

// ==== bench/timer_ctrl_checker.sv ====
// Port-level assertions for the timer control block
`timescale 1ns/1ps
`default_nettype none
module timer_ctrl_checker
    import timer_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              ext_irq0_pin,
    input wire logic              timer0_irq,
    input wire logic              timer1_irq,
    input wire logic              ext_irq0_irq
);
    logic       wr_ok;
    logic [7:0] idx;
    logic [7:0] svc;
    logic [7:0] ctrl_q;
    logic [7:0] mode_q;
    // Accepted accesses, decoded once
    assign idx   = avs_address[9:2];
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign svc   = (wr_ok && idx == IDX_SERVICE) ? avs_writedata[7:0] : 8'h00;
    // Software view only; hardware-set flags are not mirrored here
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= CTRL_RESET;
            mode_q <= MODE_RESET;
        end
        else if (wr_ok && idx == IDX_CTRL)
            ctrl_q <= avs_writedata[7:0];
        else if (wr_ok && idx == IDX_MODE)
            mode_q <= avs_writedata[7:0];
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // Pin low long enough to cross the synchroniser
    sequence s_low0;
        $fell(ext_irq0_pin) ##1 !ext_irq0_pin [*3];
    endsequence
    sequence s_quiet0;
        ext_irq0_pin [*3];
    endsequence
    property p_ext0_set;
        s_low0 |-> ##[0:1] ext_irq0_irq;
    endproperty
    a_ext0_set: assert property (p_ext0_set)
        else $error("ext pin 0 low left its flag clear");
    property p_lvl_keep;
        svc[SVC_EXT0] && !ctrl_q[0] && ext_irq0_irq |=> ext_irq0_irq;
    endproperty
    a_lvl_keep: assert property (p_lvl_keep)
        else $error("level flag cleared by service");
    property p_edge_clr;
        s_quiet0 ##0 (svc[SVC_EXT0] && ctrl_q[0]) |-> ##[1:2] !ext_irq0_irq;
    endproperty
    a_edge_clr: assert property (p_edge_clr)
        else $error("edge flag not cleared by service");
    property p_t0_clr;
        svc[SVC_T0] && !ctrl_q[4] && !$past(ctrl_q[4]) |-> ##[1:2] !timer0_irq;
    endproperty
    a_t0_clr: assert property (p_t0_clr)
        else $error("timer 0 flag kept after service");
    property p_t1_clr;
        svc[SVC_T1] && !ctrl_q[6] && !$past(ctrl_q[6]) |-> ##[1:2] !timer1_irq;
    endproperty
    a_t1_clr: assert property (p_t1_clr)
        else $error("timer 1 flag kept after service");
    property p_t0_cause;
        $rose(timer0_irq) |-> ctrl_q[5] || $past(ctrl_q[4])
            || $past(ctrl_q[4], 2) || $past(ctrl_q[4], 3);
    endproperty
    a_t0_cause: assert property (p_t0_cause)
        else $error("timer 0 flag rose with run bit off");
    property p_t1_cause;
        $rose(timer1_irq) |-> ctrl_q[7] || $past(ctrl_q[6])
            || $past(ctrl_q[6], 2) || $past(ctrl_q[6], 3);
    endproperty
    a_t1_cause: assert property (p_t1_cause)
        else $error("timer 1 flag rose with run bit off");
    property p_mode_rd;
        avs_read && !avs_waitrequest && idx == IDX_MODE
            |-> avs_readdata[7:0] == mode_q;
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("mode register read differs from last write");
endmodule
bind timer_ctrl timer_ctrl_checker u_checker
(
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_irq0_pin(ext_irq0_pin), .timer0_irq(timer0_irq),
    .timer1_irq(timer1_irq), .ext_irq0_irq(ext_irq0_irq)
);
`default_nettype wire

// ==== bench/pin_model.sv ====
// Model of the interrupt and count pins outside the block
`timescale 1ns/1ps
`default_nettype none
module pin_model
(
    input  wire logic clk_sys,
    output logic      ext_irq0_pin,
    output logic      ext_irq1_pin,
    output logic      timer0_count_pin,
    output logic      timer1_count_pin
);
    logic [1:0] irq_q = 2'h3;
    logic [1:0] cnt_q = 2'h3;
    // Idle high, as the board pull-ups hold them
    assign ext_irq0_pin     = irq_q[0];
    assign ext_irq1_pin     = irq_q[1];
    assign timer0_count_pin = cnt_q[0];
    assign timer1_count_pin = cnt_q[1];
    // Interrupt pin levels, changed just after an edge
    task automatic set_irq(input logic [1:0] v);
        @(posedge clk_sys);
        irq_q <= v;
    endtask
    // Falling-edge pulses; w of 1 is the fastest the synchroniser allows
    task automatic pulse(input int t, input int n, input int w);
        repeat (n)
        begin
            @(posedge clk_sys);
            cnt_q[t] <= 1'h0;
            repeat (w) @(posedge clk_sys);
            cnt_q[t] <= 1'h1;
            repeat (w) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_timer_control_mode_regs.sv ====
// Self-checking bench for the timer control and mode registers
`timescale 1ns/1ps
`default_nettype none
module tb_timer_control_mode_regs
    import timer_pkg::*;
;
    logic              clk_sys = 1'h0;
    logic              nrst = 1'h0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'h0;
    logic              avs_write = 1'h0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [3:0]        avs_byteenable = 4'hF;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    wire logic [3:0]   pin;
    wire logic [3:0]   irq;
    int                err_total = 0;
    int                total_checks = 0;
    int                cyc = 0;
    logic [7:0]        regs[$] = '{IDX_CTRL, IDX_MODE, IDX_T0_LOW,
                                   IDX_T1_LOW, IDX_T0_HIGH, 8'h95};
    always #2.5 clk_sys = ~clk_sys;
    timer_ctrl u_timer_ctrl
    (
        .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_irq0_pin(pin[0]), .ext_irq1_pin(pin[1]),
        .timer0_count_pin(pin[2]), .timer1_count_pin(pin[3]),
        .timer0_irq(irq[0]), .timer1_irq(irq[1]),
        .ext_irq0_irq(irq[2]), .ext_irq1_irq(irq[3])
    );
    pin_model u_pin_model
    (
        .clk_sys(clk_sys), .ext_irq0_pin(pin[0]), .ext_irq1_pin(pin[1]),
        .timer0_count_pin(pin[2]), .timer1_count_pin(pin[3])
    );
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard; the run needs under a third of this
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        avs_address   <= {i, 2'h0};
        avs_write     <= w;
        avs_read      <= !w;
        // Unused data and enable bits carry noise; the block must ignore them
        avs_writedata <= {24'($urandom), d};
        avs_byteenable[3:1] <= 3'($urandom);
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'h0);
        q = avs_readdata[7:0];
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(1'h1, i, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(1'h0, i, 8'h00, q);
        chk(q, e);
    endtask
    // Reference: one increment of the selected mode
    function automatic void step(input int m, inout int lo, inout int hi,
                                 inout int ov);
        int c;
        c  = (m == 0) ? 32 : 256;
        lo = (m == 0) ? (lo & 224) | ((lo + 1) % 32) : (lo + 1) % 256;
        if (lo % c == 0 && m >= 2)
            ov = 1;
        if (lo % c == 0 && m == 2)
            lo = hi;
        else if (lo % c == 0 && m < 2)
        begin
            hi = (hi + 1) % 256;
            ov = ov | (hi == 0);
        end
    endfunction
    // Pulses counted in one mode, start values near the wrap
    task automatic count_run(input int t, input int m);
        int lo;
        int hi;
        int ov;
        int n;
        lo = $urandom % 256;
        hi = 255 - $urandom % 2;
        n  = 20 + $urandom % 50;
        ov = 0;
        wr(IDX_CTRL, CTRL_RESET);
        wr(IDX_MODE, 8'((4 + m) << (4 * t)));
        wr(8'(IDX_T0_LOW + t), 8'(lo));
        wr(8'(IDX_T0_HIGH + t), 8'(hi));
        wr(IDX_CTRL, 8'(16 << (2 * t)));
        u_pin_model.pulse(t, n, 2 + t);
        if (t == 0 || m != 3)
            repeat (n) step(m, lo, hi, ov);
        repeat (6) @(posedge clk_sys);
        rd_chk(8'(IDX_T0_LOW + t), 8'(lo));
        rd_chk(8'(IDX_T0_HIGH + t), 8'(hi));
        rd_chk(IDX_CTRL, 8'((16 + 32 * ov) << (2 * t)));
        chk({7'h0, irq[t]}, 8'(ov));
        wr(IDX_SERVICE, 8'h0A);
        rd_chk(IDX_CTRL, 8'(16 << (2 * t)));
        $display("count test timer %0d mode %0d done", t, m);
    endtask
    initial
    begin
        logic [7:0] q;
        logic [7:0] v;
        void'($urandom(32'h9C76));
        repeat (2) @(posedge clk_sys);
        nrst <= 1'h1;
        foreach (regs[k]) rd_chk(regs[k], 8'h00);
        v = 8'($urandom);
        wr(IDX_MODE, v);
        avs_byteenable <= 4'h0;
        wr(IDX_MODE, ~v);
        avs_byteenable <= 4'hF;
        rd_chk(IDX_MODE, v);
        $display("reset and mode readback test done");
        for (int t = 0; t < 2; t++)
            for (int m = 0; m < 4; m++)
                count_run(t, m);
        wr(IDX_MODE, 8'h0D);
        wr(IDX_T0_LOW, 8'h00);
        wr(IDX_CTRL, 8'h10);
        u_pin_model.set_irq(2'h2);
        u_pin_model.pulse(0, 5, 2);
        u_pin_model.set_irq(2'h3);
        rd_chk(IDX_T0_LOW, 8'h00);
        u_pin_model.pulse(0, 5, 2);
        repeat (6) @(posedge clk_sys);
        rd_chk(IDX_T0_LOW, 8'h05);
        wr(IDX_MODE, 8'h05);
        u_pin_model.set_irq(2'h2);
        u_pin_model.pulse(0, 5, 2);
        u_pin_model.set_irq(2'h3);
        repeat (6) @(posedge clk_sys);
        rd_chk(IDX_T0_LOW, 8'h0A);
        $display("gating test done");
        wr(IDX_CTRL, 8'h00);
        wr(IDX_MODE, 8'h01);
        wr(IDX_T0_LOW, 8'h00);
        wr(IDX_CTRL, 8'h10);
        repeat (120) @(posedge clk_sys);
        wr(IDX_CTRL, 8'h00);
        bus(1'h0, IDX_T0_LOW, 8'h00, q);
        chk(8'(q >= 20 && q <= 21), 8'h01);
        $display("timer clock test done");
        u_pin_model.set_irq(2'h0);
        repeat (6) @(posedge clk_sys);
        rd_chk(IDX_CTRL, 8'h0A);
        chk({4'h0, irq}, 8'h0C);
        wr(IDX_SERVICE, 8'h0F);
        rd_chk(IDX_CTRL, 8'h0A);
        u_pin_model.set_irq(2'h3);
        repeat (4) @(posedge clk_sys);
        wr(IDX_CTRL, 8'h05);
        u_pin_model.set_irq(2'h0);
        u_pin_model.set_irq(2'h3);
        repeat (6) @(posedge clk_sys);
        rd_chk(IDX_CTRL, 8'h0F);
        wr(IDX_SERVICE, 8'h0B);
        rd_chk(IDX_CTRL, 8'h0D);
        $display("external flag test done");
        print_verdict();
    end
endmodule
`default_nettype wire
